// ==== core/adsw_map.vh ====
// Purpose: Register offsets, field positions, reset values and timing counts for the aperture delay block.
// Assumes: Byte addresses on a 32-bit APB bus, one register per aligned word.
// Notes: Definitions only.
`ifndef ADSW_MAP_VH
`define ADSW_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADSW_OFF_DELAY 12'h000
`define ADSW_OFF_RAMP 12'h004
`define ADSW_OFF_APPLIED 12'h008
`define ADSW_OFF_REFPOS 12'h00C
`define ADSW_OFF_REFSEL 12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADSW_FINE_LSB 0
`define ADSW_COARSE_LSB 8
`define ADSW_INVERT_BIT 16
`define ADSW_RAMP_EN_BIT 0
`define ADSW_RAMP_RATE_BIT 1
`define ADSW_BUSY_BIT 8
`define ADSW_POS_VALID_BIT 31
`define ADSW_SEL_LSB 0
`define ADSW_SINGLE_BIT 4
`define ADSW_REARM_BIT 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADSW_RST_CODE 8'h00
`define ADSW_RST_SEL 4'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define ADSW_RAMP_PERIOD 384
`define ADSW_SLOW_STEP 8'h01
`define ADSW_FAST_STEP 8'h04
`define ADSW_MIN_REF_EDGES 3
`define ADSW_POS_TAPS 24

`endif

// ==== core/adsw_refpos.v ====
// Purpose: Reference position detector and capture with a selectable delayed clock copy.
// Assumes: Reference pin and tap samples are asynchronous to clk.
// Notes: Taps are level samples of the reference taken by delayed copies of the device clock.
`timescale 1ns/100ps
`include "adsw_map.vh"
module adsw_refpos
#(
  parameter NTAPS = `ADSW_POS_TAPS,
  parameter SELW = 4
)
(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Reference and tap samples
  input wire refPin,
  input wire [NTAPS-1:0] tapSample,
  // Control
  input wire [SELW-1:0] captureSelect,
  input wire rearm,
  // Status
  output reg [NTAPS-1:0] positionStatus,
  output wire positionValid,
  output reg refCaptured
);
  reg refS1;
  reg refS2;
  reg refS3;
  reg [NTAPS-1:0] tapS1;
  reg [NTAPS-1:0] tapS2;
  reg [1:0] edgeCount;
  wire refRise;
  wire [NTAPS-1:0] flags;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refS1 <= 1'b0;
      refS2 <= 1'b0;
      refS3 <= 1'b0;
      tapS1 <= {NTAPS{1'b0}};
      tapS2 <= {NTAPS{1'b0}};
    end
    else
    begin
      refS1 <= refPin;
      refS2 <= refS1;
      refS3 <= refS2;
      tapS1 <= tapSample;
      tapS2 <= tapS1;
    end
  end

  assign refRise = refS2 & ~refS3;

  // ----------------------------------------------------------------
  // Violation flags
  // ----------------------------------------------------------------
  // A tap next to a level change sits on the reference edge and is marked.
  assign flags[0] = 1'b1;
  assign flags[NTAPS-1] = 1'b1;
  genvar i;
  generate
    for (i = 1; i < NTAPS - 1; i = i + 1)
    begin : gFlag
      assign flags[i] = (tapS2[i] ^ tapS2[i-1]) | (tapS2[i] ^ tapS2[i+1]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status capture
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      edgeCount <= 2'h0;
      positionStatus <= {NTAPS{1'b1}};
    end
    else
    begin
      // A rise in the rearm cycle still counts, so that edge is never lost.
      if (refRise)
      begin
        positionStatus <= flags;
      end
      if (rearm)
      begin
        edgeCount <= refRise ? 2'h1 : 2'h0;
      end
      else if (refRise && edgeCount != 2'h3)
      begin
        edgeCount <= edgeCount + 2'h1;
      end
    end
  end

  assign positionValid = (edgeCount >= 2'h3);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refCaptured <= 1'b0;
    end
    else
    begin
      refCaptured <= tapS2[captureSelect];
    end
  end
endmodule

// ==== core/adsw_core.v ====
// Purpose: Aperture delay control with coarse ramp and reference capture windowing, on APB.
// Assumes: Single clock; analog delay lines and tap samplers sit outside and follow the code outputs.
// Notes: APB answers with no wait state; unmapped addresses answer with pslverr.
`timescale 1ns/100ps
`include "adsw_map.vh"
module adsw_core
#(
  parameter CODEW = 8,
  parameter SELW = 4,
  parameter NTAPS = `ADSW_POS_TAPS,
  parameter RAMP_PERIOD = `ADSW_RAMP_PERIOD
)
(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Reference windowing
  input wire refPin,
  input wire [NTAPS-1:0] tapSample,
  output wire refCaptured,
  output wire [SELW-1:0] referenceCaptureSelect,
  // Delay line controls
  output reg clockInvertDelay,
  output reg [CODEW-1:0] coarseDelayCode,
  output reg [CODEW-1:0] fineDelayCode,
  output reg dualEdgeSample,
  output wire rampBusy
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function addrHit;
    input [11:0] addr;
    begin
      if (addr == `ADSW_OFF_DELAY)
        addrHit = 1'b1;
      else if (addr == `ADSW_OFF_RAMP)
        addrHit = 1'b1;
      else if (addr == `ADSW_OFF_APPLIED)
        addrHit = 1'b1;
      else if (addr == `ADSW_OFF_REFPOS)
        addrHit = 1'b1;
      else if (addr == `ADSW_OFF_REFSEL)
        addrHit = 1'b1;
      else
        addrHit = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [CODEW-1:0] coarseTarget;
  reg rampEnable;
  reg rampRateSelect;
  reg [SELW-1:0] captureSel;
  reg rearm;
  reg [8:0] rampCount;
  reg [31:0] next_prdata;
  reg [CODEW-1:0] distance;
  reg [CODEW-1:0] stepSize;
  reg [CODEW-1:0] moveBy;
  reg [CODEW-1:0] next_coarse;
  wire accessPhase;
  wire writeDelay;
  wire writeRamp;
  wire writeSel;
  wire rampTick;
  wire [NTAPS-1:0] positionStatus;
  wire positionValid;

  localparam integer RAMP_LAST_I = RAMP_PERIOD - 1;
  localparam [8:0] RAMP_LAST = RAMP_LAST_I[8:0];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // No wait states: the access phase always completes in one cycle.
  assign accessPhase = psel & penable;
  assign pready = accessPhase;
  assign pslverr = accessPhase & ~addrHit(paddr);

  assign writeDelay = accessPhase & pwrite & (paddr == `ADSW_OFF_DELAY);
  assign writeRamp = accessPhase & pwrite & (paddr == `ADSW_OFF_RAMP);
  assign writeSel = accessPhase & pwrite & (paddr == `ADSW_OFF_REFSEL);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data is latched in the setup cycle so prdata comes from a flip-flop.
  always @*
  begin
    next_prdata = 32'h00000000;
    if (paddr == `ADSW_OFF_DELAY)
    begin
      next_prdata[`ADSW_FINE_LSB +: 8] = fineDelayCode;
      next_prdata[`ADSW_COARSE_LSB +: 8] = coarseTarget;
      next_prdata[`ADSW_INVERT_BIT] = clockInvertDelay;
    end
    else if (paddr == `ADSW_OFF_RAMP)
    begin
      next_prdata[`ADSW_RAMP_EN_BIT] = rampEnable;
      next_prdata[`ADSW_RAMP_RATE_BIT] = rampRateSelect;
    end
    else if (paddr == `ADSW_OFF_APPLIED)
    begin
      next_prdata[7:0] = coarseDelayCode;
      next_prdata[`ADSW_BUSY_BIT] = rampBusy;
    end
    else if (paddr == `ADSW_OFF_REFPOS)
    begin
      next_prdata[NTAPS-1:0] = positionStatus;
      next_prdata[`ADSW_POS_VALID_BIT] = positionValid;
    end
    else if (paddr == `ADSW_OFF_REFSEL)
    begin
      next_prdata[`ADSW_SEL_LSB +: 4] = captureSel;
      next_prdata[`ADSW_SINGLE_BIT] = dualEdgeSample;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel & ~penable & ~pwrite)
    begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Delay control registers
  // ----------------------------------------------------------------
  // Writes land at any time; fine and invert follow at once, coarse one cycle later and only with the ramp off, which may upset the link briefly.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clockInvertDelay <= 1'b0;
      fineDelayCode <= `ADSW_RST_CODE;
      coarseTarget <= `ADSW_RST_CODE;
    end
    else if (writeDelay)
    begin
      clockInvertDelay <= pwdata[`ADSW_INVERT_BIT];
      fineDelayCode <= pwdata[`ADSW_FINE_LSB +: 8];
      coarseTarget <= pwdata[`ADSW_COARSE_LSB +: 8];
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rampEnable <= 1'b0;
      rampRateSelect <= 1'b0;
    end
    else if (writeRamp)
    begin
      rampEnable <= pwdata[`ADSW_RAMP_EN_BIT];
      rampRateSelect <= pwdata[`ADSW_RAMP_RATE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Reference select and mode
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      captureSel <= `ADSW_RST_SEL;
      dualEdgeSample <= 1'b0;
      rearm <= 1'b0;
    end
    else
    begin
      rearm <= writeSel & pwdata[`ADSW_REARM_BIT];
      if (writeSel)
      begin
        captureSel <= pwdata[`ADSW_SEL_LSB +: 4];
        dualEdgeSample <= pwdata[`ADSW_SINGLE_BIT];
      end
    end
  end

  assign referenceCaptureSelect = captureSel;

  // ----------------------------------------------------------------
  // Coarse ramp
  // ----------------------------------------------------------------
  assign rampBusy = rampEnable & (coarseDelayCode != coarseTarget);
  assign rampTick = (rampCount == RAMP_LAST);

  // The step is clipped to the remaining distance so the code never overshoots.
  always @*
  begin
    if (coarseTarget > coarseDelayCode)
      distance = coarseTarget - coarseDelayCode;
    else
      distance = coarseDelayCode - coarseTarget;
    stepSize = rampRateSelect ? `ADSW_FAST_STEP : `ADSW_SLOW_STEP;
    moveBy = (distance < stepSize) ? distance : stepSize;
    if (coarseTarget > coarseDelayCode)
      next_coarse = coarseDelayCode + moveBy;
    else
      next_coarse = coarseDelayCode - moveBy;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rampCount <= 9'h000;
    end
    else if (writeDelay | ~rampBusy)
    begin
      rampCount <= 9'h000;
    end
    else if (rampTick)
    begin
      rampCount <= 9'h000;
    end
    else
    begin
      rampCount <= rampCount + 9'h001;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      coarseDelayCode <= `ADSW_RST_CODE;
    end
    else if (!rampEnable)
    begin
      coarseDelayCode <= coarseTarget;
    end
    // A coarse write on a step edge suppresses that step, so the code never moves away from the new target.
    else if (rampBusy & rampTick & ~writeDelay)
    begin
      coarseDelayCode <= next_coarse;
    end
  end

  // ----------------------------------------------------------------
  // Reference windowing
  // ----------------------------------------------------------------
  // Taps are clocked by the delayed device clock, so the capture moves with the delay.
  adsw_refpos
  #(
    .NTAPS(NTAPS),
    .SELW(SELW)
  )
  uRefPos
  (
    .clk(clk),
    .resetn(resetn),
    .refPin(refPin),
    .tapSample(tapSample),
    .captureSelect(captureSel),
    .rearm(rearm),
    .positionStatus(positionStatus),
    .positionValid(positionValid),
    .refCaptured(refCaptured)
  );

endmodule

// ==== test/adsw_core_properties.sv ====
// Purpose: Port-level properties of the aperture delay block.
// Assumes: A write lands at the access edge of its APB transfer.
// Notes: Bound to the top module from the bench top file.
`timescale 1ns/100ps
module adsw_core_properties
#(
  parameter CODEW = 8,
  parameter SELW = 4,
  parameter NTAPS = 24,
  parameter RAMP_PERIOD = 384
)
(
  // Clock and reset
  input wire clk,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Reference and delay
  input wire refPin,
  input wire [NTAPS-1:0] tapSample,
  input wire refCaptured,
  input wire [SELW-1:0] referenceCaptureSelect,
  input wire clockInvertDelay,
  input wire [CODEW-1:0] coarseDelayCode,
  input wire [CODEW-1:0] fineDelayCode,
  input wire dualEdgeSample,
  input wire rampBusy
);
  wire apbWr = psel && penable && pwrite;
  wire selTap = tapSample[referenceCaptureSelect];
  reg [15:0] sinceStep;
  reg [CODEW-1:0] lastCode;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Restarts on a delay write and counts from one after each step, so a step sees the full period.
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sinceStep <= 16'h0000;
      lastCode <= {CODEW{1'b0}};
    end
    else
    begin
      lastCode <= coarseDelayCode;
      if (apbWr && paddr == 12'h000)
        sinceStep <= 16'h0000;
      else if (coarseDelayCode != lastCode)
        sinceStep <= 16'h0001;
      else
        sinceStep <= sinceStep + 16'h0001;
    end
  end
  a_pready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready outside access phase");
  a_step_size: assert property ($past(rampBusy && !apbWr) && $changed(coarseDelayCode) |->
    (coarseDelayCode - $past(coarseDelayCode) <= 4) || ($past(coarseDelayCode) - coarseDelayCode <= 4))
    else $error("coarse step too large");
  a_step_spacing: assert property ($past(rampBusy && !apbWr) && $changed(coarseDelayCode) |->
    sinceStep == RAMP_PERIOD) else $error("coarse step off period");
  a_idle_hold: assert property (!$past(rampBusy) && !$past(apbWr) && !$past(apbWr, 2) |->
    $stable({clockInvertDelay, coarseDelayCode, fineDelayCode})) else $error("delay moved while idle");
  a_no_jump: assert property ($past(apbWr && paddr == 12'h000) && rampBusy |->
    $stable(coarseDelayCode)) else $error("coarse jumped with ramp on");
  a_delay_write: assert property ($past(apbWr && paddr == 12'h000) |->
    fineDelayCode == $past(pwdata[7:0]) && clockInvertDelay == $past(pwdata[16])) else $error("delay write lost");
  a_select_write: assert property ($past(apbWr && paddr == 12'h010) |->
    referenceCaptureSelect == $past(pwdata[3:0]) && dualEdgeSample == $past(pwdata[4])) else $error("select lost");
  a_capture_tap: assert property (referenceCaptureSelect == $past(referenceCaptureSelect, 3) |->
    refCaptured == $past(selTap, 3)) else $error("capture tap mismatch");
  a_end_taps: assert property (psel && penable && !pwrite && paddr == 12'h00C |->
    prdata[0] && prdata[23]) else $error("end taps not flagged");
endmodule

// ==== test/adsw_ref_source.sv ====
// Purpose: Reference source model feeding the reference pin and the tap samples.
// Assumes: Each tap is the reference level seen by one delayed clock copy.
// Notes: The edge pattern holds six cycles after each rise, then every tap sees high.
`timescale 1ns/100ps
module adsw_ref_source
(
  // Clock
  input wire clk,
  // Bench control
  input wire run,
  input wire [23:0] edgePattern,
  // Reference outputs
  output reg refPin,
  output reg [23:0] tapSample
);
  reg [3:0] phase;
  initial
  begin
    phase = 4'h0;
    refPin = 1'b0;
    tapSample = 24'h000000;
  end
  // The pin is driven low when idle, so the capture never sees a floating level.
  always @(posedge clk)
  begin
    phase <= run ? phase + 4'h1 : 4'h0;
    refPin <= run && phase < 4'h8;
    tapSample <= (!run || phase > 4'h7) ? 24'h000000 : (phase < 4'h6 ? edgePattern : 24'hFFFFFF);
  end
endmodule

// ==== test/adsw_core_bench.sv ====
// Purpose: Self-checking bench for the aperture delay block.
// Assumes: A short ramp period keeps ramps brief.
// Notes: Register traffic goes through one APB task.
`timescale 1ns/100ps
module adsw_core_bench;
  localparam PER = 8;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg run = 1'b0;
  reg [23:0] pat = 24'hFFFE00;
  wire [31:0] prdata;
  wire pready, pslverr, refPin, refCaptured, clockInvertDelay, dualEdgeSample, rampBusy;
  wire [23:0] tapSample;
  wire [3:0] refSel;
  wire [7:0] coarse, fine;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer i, cnt;
  reg [31:0] q, d;
  reg e;
  reg [3:0] s;
  // Taps 8 and 9 straddle the level change of the pattern; the end taps always read 1.
  reg [23:0] expPos = 24'h800301;
  always #12.5 clk = ~clk;
  adsw_core #(.RAMP_PERIOD(PER)) i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refPin(refPin), .tapSample(tapSample), .refCaptured(refCaptured), .referenceCaptureSelect(refSel),
    .clockInvertDelay(clockInvertDelay), .coarseDelayCode(coarse), .fineDelayCode(fine),
    .dualEdgeSample(dualEdgeSample), .rampBusy(rampBusy));
  adsw_ref_source i_src (.clk(clk), .run(run), .edgePattern(pat), .refPin(refPin), .tapSample(tapSample));
  task chk(input string nm, input [31:0] x, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== x)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task acc(input w, input [11:0] a, input [31:0] dt);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the watchdog ends a wait for pready.
      while (pready !== 1'b1)
        @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input string nm, input [11:0] a, input [31:0] x);
    begin
      acc(1'b0, a, 32'h00000000);
      chk(nm, x, q);
    end
  endtask
  task ramp(input [7:0] tgt, input [7:0] st, input integer steps);
    integer n, k;
    reg [7:0] pv, xv;
    begin
      acc(1'b1, 12'h000, {16'h0000, tgt, 8'h00});
      chk("busy", 1, rampBusy);
      pv = coarse;
      n = 0;
      k = 0;
      while (coarse !== tgt && n < 100 * PER)
      begin
        @(posedge clk);
        n = n + 1;
        if (coarse !== pv)
        begin
          if (tgt > pv)
            xv = (tgt - pv > st) ? pv + st : tgt;
          else
            xv = (pv - tgt > st) ? pv - st : tgt;
          chk("coarse step", xv, coarse);
          pv = coarse;
          k = k + 1;
        end
      end
      chk("step count", steps, k);
      chk("busy", 0, rampBusy);
      rd("applied", 12'h008, {24'h000000, tgt});
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6000) @(posedge clk);
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("outputs", 0, {clockInvertDelay, coarse, fine, dualEdgeSample, refSel, rampBusy});
    rd("refpos", 12'h00C, 32'h00FFFFFF);
    rd("ramp", 12'h004, 32'h0);
    $display("test reset done");
    for (i = 0; i < 3; i = i + 1)
    begin
      d = (i == 0) ? 32'h0001FF00 : (i == 1) ? 32'h000000FF : 32'h0001A55A;
      acc(1'b1, 12'h000, d);
      repeat (2) @(posedge clk);
      chk("delay pins", d[16:0], {clockInvertDelay, coarse, fine});
      rd("delay", 12'h000, d);
    end
    acc(1'b0, 12'h014, 32'h0);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    acc(1'b1, 12'h008, 32'hFFFFFFFF);
    chk("ro error", 0, e);
    rd("applied", 12'h008, 32'h000000A5);
    $display("test delay done");
    acc(1'b1, 12'h004, 32'h1);
    ramp(8'hA8, 8'h01, 3);
    acc(1'b1, 12'h004, 32'h3);
    rd("ramp", 12'h004, 32'h3);
    ramp(8'hB2, 8'h04, 3);
    ramp(8'hA9, 8'h04, 3);
    acc(1'b1, 12'h004, 32'h1);
    acc(1'b1, 12'h000, 32'h0000B000);
    repeat (12) @(posedge clk);
    ramp(8'hA9, 8'h01, 1);
    $display("test ramp done");
    acc(1'b1, 12'h010, 32'h100);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    rd("refpos early", 12'h00C, {8'h00, expPos});
    run <= 1'b1;
    repeat (10) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    rd("refpos valid", 12'h00C, {8'h80, expPos});
    $display("test position done");
    for (i = 0; i < 2; i = i + 1)
    begin
      s = i ? 4'hF : 4'h4;
      acc(1'b1, 12'h010, {27'h0, 1'b1, s});
      chk("select pins", {1'b1, s}, {dualEdgeSample, refSel});
      rd("select", 12'h010, {27'h0, 1'b1, s});
      run <= 1'b1;
      repeat (8) @(posedge clk);
      cnt = 0;
      repeat (32)
      begin
        @(posedge clk);
        cnt = cnt + (refCaptured === 1'b1);
      end
      run <= 1'b0;
      chk("capture ones", i ? 16 : 4, cnt);
    end
    repeat (8) @(posedge clk);
    acc(1'b1, 12'h010, 32'h10F);
    rd("select rearm", 12'h010, 32'h0000000F);
    rd("refpos rearm", 12'h00C, {8'h00, expPos});
    $display("test capture done");
    print_verdict;
  end
endmodule
bind adsw_core adsw_core_properties #(.CODEW(CODEW), .SELW(SELW), .NTAPS(NTAPS), .RAMP_PERIOD(RAMP_PERIOD))
  i_props (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .refPin(refPin),
  .tapSample(tapSample), .refCaptured(refCaptured), .referenceCaptureSelect(referenceCaptureSelect),
  .clockInvertDelay(clockInvertDelay), .coarseDelayCode(coarseDelayCode), .fineDelayCode(fineDelayCode),
  .dualEdgeSample(dualEdgeSample), .rampBusy(rampBusy));
